/* File: rtl/data_memory_map.svh */
`ifndef DATA_MEMORY_MAP_SVH
`define DATA_MEMORY_MAP_SVH

// Data space geometry
`define DM_ADDR_W        12
`define DM_DATA_W        8
`define DM_BANK_W        4
`define DM_GPR_DEPTH     3968
`define DM_SFR_BASE      12'hF80
`define DM_BOOT_BANK_LO  4'h4
`define DM_BOOT_BANK_HI  4'h5
`define DM_ACC_SPLIT     8'h80
`define DM_ACC_HI_BANK   4'hF
`define DM_ACC_LO_BANK   4'h0

// Implemented special registers
`define DM_ADR_EXT_MEM   12'hF90
`define DM_ADR_WATCHDOG  12'hF91
`define DM_ADR_OSC       12'hF92
`define DM_ADR_CS_TWO    12'hF93
`define DM_ADR_IO_CS     12'hF94
`define DM_ADR_PAR_PORT  12'hF95
`define DM_RST_EXT_MEM   8'h00
`define DM_RST_WATCHDOG  8'h00
`define DM_RST_OSC       8'h00
`define DM_RST_CS_TWO    8'h00
`define DM_RST_IO_CS     8'h00
`define DM_RST_PAR_PORT  8'h00
`define DM_BOOT_RAM_PROGRAM_SELECT_BIT      6
`define DM_LOCK_FIRST    2'b01
`define DM_LOCK_BOTH     2'b11

// APB map: paddr[15:14] selects a region
`define DM_REG_FLAT      2'b00
`define DM_REG_DIRECT    2'b01
`define DM_REG_CTRL      2'b10
`define DM_DIR_ACC_BIT   10
`define DM_CTL_BANK      6'h00
`define DM_CTL_PTR0      6'h01
`define DM_CTL_PTR1      6'h02
`define DM_CTL_PTR2      6'h03
`define DM_CTL_IND0      6'h04
`define DM_CTL_IND1      6'h05
`define DM_CTL_IND2      6'h06
`define DM_CTL_MV_SRC    6'h07
`define DM_CTL_MV_DST    6'h08
`define DM_CTL_STATUS    6'h09

`endif

/* File: rtl/data_memory_pkg.sv */
`include "data_memory_map.svh"
package data_memory_pkg;
   typedef logic [`DM_ADDR_W-1:0] data_addr_t;
   typedef logic [`DM_DATA_W-1:0] data_byte_t;

   typedef struct packed {
      logic       en;
      data_addr_t addr;
      data_byte_t data;
   } mem_wr_s;

   typedef struct packed {
      data_byte_t watchdog_control;
      data_byte_t external_memory_control;
      data_byte_t oscillator_control;
      data_byte_t chip_select_config_two;
      data_byte_t io_chip_select_config;
   } secure_regs_s;

   typedef enum logic [1:0] {
      LOCK_IDLE  = 2'b00,
      LOCK_ARMED = 2'b01,
      LOCK_OPEN  = 2'b11
   } lock_state_e;

   typedef enum logic [1:0] {
      MV_IDLE  = 2'b00,
      MV_READ  = 2'b01,
      MV_WRITE = 2'b11
   } mv_state_e;

   function automatic logic is_secured(input data_addr_t a);
      return (a == `DM_ADR_WATCHDOG) || (a == `DM_ADR_EXT_MEM) || (a == `DM_ADR_OSC)
          || (a == `DM_ADR_CS_TWO) || (a == `DM_ADR_IO_CS);
   endfunction
endpackage

/* File: rtl/bank_address_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module bank_address_decode
   import data_memory_pkg::*;
(
   // Bus address
   input  wire logic [15:0]     paddr,
   // Addressing state
   input  wire logic [3:0]      bank_sel,
   input  wire data_addr_t [2:0] ptrs,
   // Decoded target
   output logic                 data_hit,
   output data_addr_t           data_addr,
   output logic                 ctrl_hit,
   output logic [5:0]           ctrl_idx,
   output logic                 unmapped
);
   wire [1:0]  region   = paddr[15:14];
   wire [7:0]  offset   = paddr[9:2];
   wire        banked   = paddr[`DM_DIR_ACC_BIT];
   wire [5:0]  idx      = paddr[7:2];
   wire        is_flat  = region == `DM_REG_FLAT;
   wire        is_dir   = region == `DM_REG_DIRECT;
   wire        is_ctl   = region == `DM_REG_CTRL;
   wire        is_ind   = is_ctl && (idx == `DM_CTL_IND0 || idx == `DM_CTL_IND1
                                     || idx == `DM_CTL_IND2);
   wire [1:0]  ind_sel  = 2'(idx - `DM_CTL_IND0);
   wire        ctl_reg  = is_ctl && (idx <= `DM_CTL_STATUS) && !is_ind;
   // Access bank: low half from bank 0, high half from bank 15
   wire [3:0]  acc_bank = (offset < `DM_ACC_SPLIT) ? `DM_ACC_LO_BANK : `DM_ACC_HI_BANK; // [RULE10]
   wire [3:0]  dir_bank = banked ? bank_sel : acc_bank; // [RULE3] [RULE14]

   assign data_addr = is_flat ? paddr[13:2]                  // [RULE1]
                    : is_ind  ? ptrs[ind_sel]                // [RULE8]
                    : {dir_bank, offset};                    // [RULE2]
   assign data_hit  = is_flat || is_dir || is_ind;
   assign ctrl_hit  = ctl_reg;
   assign ctrl_idx  = idx;
   assign unmapped  = !(data_hit || ctl_reg);
endmodule
`default_nettype wire

/* File: rtl/secure_write_lock.sv */
`timescale 1ns/1ps
`default_nettype none
module secure_write_lock
   import data_memory_pkg::*;
(
   // Clock and reset
   input  wire logic    pclk,
   input  wire logic    presetn,
   // Data space write stream
   input  wire mem_wr_s wr,
   // Lock state
   output lock_state_e  state
);
   lock_state_e state_nxt;
   wire par_wr  = wr.en && (wr.addr == `DM_ADR_PAR_PORT);
   wire sec_wr  = wr.en && is_secured(wr.addr);
   wire [1:0] b = wr.data[1:0];

   // First bit alone, then both bits, opens the lock
   always_comb begin
      state_nxt = state;
      unique case (state)
         LOCK_IDLE:  if (par_wr && b == `DM_LOCK_FIRST) state_nxt = LOCK_ARMED; // [RULE13]
         LOCK_ARMED: if (par_wr) begin
            if (b == `DM_LOCK_BOTH)
               state_nxt = LOCK_OPEN;
            else if (b != `DM_LOCK_FIRST)
               state_nxt = LOCK_IDLE;
         end
         LOCK_OPEN: begin
            if (sec_wr)
               state_nxt = LOCK_IDLE; // [RULE15]
            else if (par_wr && b != `DM_LOCK_BOTH)
               state_nxt = LOCK_IDLE;
         end
         default: state_nxt = LOCK_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         state <= LOCK_IDLE;
      else
         state <= state_nxt;
   end
endmodule
`default_nettype wire

/* File: rtl/banked_data_memory.sv */
// Notes on behaviour
// [RULE1] Twelve-bit addresses span 4096 bytes
// [RULE2] Data space splits into 256-byte banks
// [RULE3] Low four bank-select bits pick bank
// [RULE4] Special registers top down, general bottom up
// [RULE5] Bank 15 from F80 holds special registers
// [RULE6] Unimplemented locations read as zero
// [RULE7] Boot mode hides banks 4 and 5
// [RULE8] Pointers hold full address, ignore banking
// [RULE9] Register move copies across banks, two cycles
// [RULE10] Access bank: bank 0 and 15 segments
// [RULE11] General registers never reset
// [RULE12] Five control registers are write protected
// [RULE13] Software sets lock bits in order first
// [RULE14] Direct address is bank above offset
// [RULE15] One protected write per unlock, then relock
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory
   import data_memory_pkg::*;
(
   // Clock and reset
   input  wire logic    pclk,
   input  wire logic    presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Protected control values
   output secure_regs_s     secure_regs,
   // Mode outputs
   output logic             boot_ram_program_select,
   output logic [3:0]       bank_select
);
   // Storage
   data_byte_t gpr_mem [0:`DM_GPR_DEPTH-1];
   logic [3:0]       bank_select_register;
   data_addr_t [2:0] indirect_pointer_register;
   data_addr_t       mv_src_r;
   data_addr_t       mv_dst_r;
   data_byte_t       mv_data_r;
   data_byte_t       parallel_port_control_r;
   secure_regs_s     sec_r;
   mv_state_e        mv_state_r;
   mv_state_e        mv_state_nxt;
   lock_state_e      lock_state;
   logic [31:0]      prdata_r;
   logic             pready_r;
   logic             pslverr_r;

   // Decode
   logic       data_hit;
   data_addr_t data_addr;
   logic       ctrl_hit;
   logic [5:0] ctrl_idx;
   logic       unmapped;

   bank_address_decode u_decode (
      .paddr     (paddr),
      .bank_sel  (bank_select_register),
      .ptrs      (indirect_pointer_register),
      .data_hit  (data_hit),
      .data_addr (data_addr),
      .ctrl_hit  (ctrl_hit),
      .ctrl_idx  (ctrl_idx),
      .unmapped  (unmapped)
   );

   // Boot RAM overlay check
   function automatic logic boot_hidden(input data_addr_t a);
      return sec_r.external_memory_control[`DM_BOOT_RAM_PROGRAM_SELECT_BIT]
          && (a[11:8] == `DM_BOOT_BANK_LO || a[11:8] == `DM_BOOT_BANK_HI); // [RULE7]
   endfunction

   // General registers below the special area, special registers at the top
   function automatic logic is_gpr(input data_addr_t a);
      return a < `DM_SFR_BASE; // [RULE4] [RULE5]
   endfunction

   // Byte read of any data location
   function automatic data_byte_t read_byte(input data_addr_t a);
      data_byte_t v;
      v = 8'h00;
      if (is_gpr(a)) begin
         if (!boot_hidden(a))
            v = gpr_mem[a]; // [RULE7]
      end else begin
         unique case (a)
            `DM_ADR_EXT_MEM:  v = sec_r.external_memory_control;
            `DM_ADR_WATCHDOG: v = sec_r.watchdog_control;
            `DM_ADR_OSC:      v = sec_r.oscillator_control;
            `DM_ADR_CS_TWO:   v = sec_r.chip_select_config_two;
            `DM_ADR_IO_CS:    v = sec_r.io_chip_select_config;
            `DM_ADR_PAR_PORT: v = {parallel_port_control_r[7:2], lock_state};
            default:          v = 8'h00; // [RULE6]
         endcase
      end
      return v;
   endfunction

   // Bus phases
   wire setup       = psel && !penable;
   wire access_done = psel && penable && pready_r;
   wire apb_wr      = access_done && pwrite && !unmapped;
   wire mv_start    = setup && pwrite && ctrl_hit && ctrl_idx == `DM_CTL_MV_DST;
   wire ctrl_wr     = apb_wr && ctrl_hit;

   // Single write stream into the data space: bus data write or move
   mem_wr_s raw_wr;
   assign raw_wr.en   = (apb_wr && data_hit) || (mv_state_r == MV_WRITE);
   assign raw_wr.addr = (mv_state_r == MV_WRITE) ? mv_dst_r : data_addr;
   assign raw_wr.data = (mv_state_r == MV_WRITE) ? mv_data_r : pwdata[7:0];

   wire lock_open = lock_state == LOCK_OPEN;
   wire sec_ok    = !is_secured(raw_wr.addr) || lock_open; // [RULE12]
   wire gpr_wr    = raw_wr.en && is_gpr(raw_wr.addr) && !boot_hidden(raw_wr.addr); // [RULE7]
   wire sfr_wr    = raw_wr.en && !is_gpr(raw_wr.addr) && sec_ok;

   secure_write_lock u_lock (
      .pclk    (pclk),
      .presetn (presetn),
      .wr      (raw_wr),
      .state   (lock_state)
   );

   // General registers: no reset term at all
   always_ff @(posedge pclk) begin
      if (gpr_wr)
         gpr_mem[raw_wr.addr] <= raw_wr.data; // [RULE11]
   end

   // Protected and ordinary special registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_r.external_memory_control <= `DM_RST_EXT_MEM;
         sec_r.watchdog_control        <= `DM_RST_WATCHDOG;
         sec_r.oscillator_control      <= `DM_RST_OSC;
         sec_r.chip_select_config_two  <= `DM_RST_CS_TWO;
         sec_r.io_chip_select_config   <= `DM_RST_IO_CS;
         parallel_port_control_r       <= `DM_RST_PAR_PORT;
      end else if (sfr_wr) begin
         unique case (raw_wr.addr)
            `DM_ADR_EXT_MEM:  sec_r.external_memory_control <= raw_wr.data; // [RULE12]
            `DM_ADR_WATCHDOG: sec_r.watchdog_control        <= raw_wr.data; // [RULE12]
            `DM_ADR_OSC:      sec_r.oscillator_control      <= raw_wr.data; // [RULE12]
            `DM_ADR_CS_TWO:   sec_r.chip_select_config_two  <= raw_wr.data; // [RULE12]
            `DM_ADR_IO_CS:    sec_r.io_chip_select_config   <= raw_wr.data; // [RULE12]
            `DM_ADR_PAR_PORT: parallel_port_control_r       <= raw_wr.data;
            default:          ;
         endcase
      end
   end

   // Bank select and indirect pointers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_select_register      <= 4'h0;
         indirect_pointer_register <= '0;
         mv_src_r                  <= 12'h000;
      end else if (ctrl_wr) begin
         unique case (ctrl_idx)
            `DM_CTL_BANK:   bank_select_register         <= pwdata[3:0]; // [RULE3]
            `DM_CTL_PTR0:   indirect_pointer_register[0] <= pwdata[11:0]; // [RULE8]
            `DM_CTL_PTR1:   indirect_pointer_register[1] <= pwdata[11:0]; // [RULE8]
            `DM_CTL_PTR2:   indirect_pointer_register[2] <= pwdata[11:0]; // [RULE8]
            `DM_CTL_MV_SRC: mv_src_r                     <= pwdata[11:0];
            default:        ;
         endcase
      end
   end

   // Register-to-register move: read cycle then write cycle
   always_comb begin
      mv_state_nxt = mv_state_r;
      unique case (mv_state_r)
         MV_IDLE:  if (mv_start) mv_state_nxt = MV_READ;
         MV_READ:  mv_state_nxt = MV_WRITE; // [RULE9]
         MV_WRITE: mv_state_nxt = MV_IDLE;
         default:  mv_state_nxt = MV_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mv_state_r <= MV_IDLE;
         mv_dst_r   <= 12'h000;
         mv_data_r  <= 8'h00;
      end else begin
         mv_state_r <= mv_state_nxt;
         if (mv_start)
            mv_dst_r <= pwdata[11:0];
         if (mv_state_r == MV_READ)
            mv_data_r <= read_byte(mv_src_r); // [RULE9]
      end
   end

   // Read data for the current setup
   logic [31:0] ctrl_rdata;
   always_comb begin
      unique case (ctrl_idx)
         `DM_CTL_BANK:   ctrl_rdata = {28'h0000000, bank_select_register};
         `DM_CTL_PTR0:   ctrl_rdata = {20'h00000, indirect_pointer_register[0]};
         `DM_CTL_PTR1:   ctrl_rdata = {20'h00000, indirect_pointer_register[1]};
         `DM_CTL_PTR2:   ctrl_rdata = {20'h00000, indirect_pointer_register[2]};
         `DM_CTL_MV_SRC: ctrl_rdata = {20'h00000, mv_src_r};
         `DM_CTL_MV_DST: ctrl_rdata = {20'h00000, mv_dst_r};
         `DM_CTL_STATUS: ctrl_rdata = {28'h0000000, mv_state_r, lock_state};
         default:        ctrl_rdata = 32'h00000000;
      endcase
   end

   wire [31:0] setup_rdata = data_hit ? {24'h000000, read_byte(data_addr)}
                           : ctrl_hit ? ctrl_rdata : 32'h00000000;

   // Zero wait states, except a move which answers after its write cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= (setup && !mv_start) || (mv_state_r == MV_WRITE);
         if (setup) begin
            prdata_r  <= pwrite ? 32'h00000000 : setup_rdata;
            pslverr_r <= unmapped;
         end
      end
   end

   assign prdata                  = prdata_r;
   assign pready                  = pready_r;
   assign pslverr                 = pslverr_r;
   assign secure_regs             = sec_r;
   assign boot_ram_program_select = sec_r.external_memory_control[`DM_BOOT_RAM_PROGRAM_SELECT_BIT];
   assign bank_select             = bank_select_register;
endmodule
`default_nettype wire

/* File: tb/bdm_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module bdm_checker
   import data_memory_pkg::*;
(
   // Clock and reset
   input wire logic         pclk,
   input wire logic         presetn,
   // APB slave
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [15:0]  paddr,
   input wire logic [31:0]  pwdata,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr,
   // Outputs
   input wire secure_regs_s secure_regs,
   input wire logic         boot_ram_program_select,
   input wire logic [3:0]   bank_select
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire setup   = psel && !penable;
   wire mv_dst  = pwrite && paddr[15:2] == 14'h2008;
   wire flat_rd = pready && !pwrite && paddr[15:14] == 2'b00;
   sequence mv_setup; setup && mv_dst; endsequence
   sequence mv_wait; !pready ##1 !pready ##1 pready; endsequence
   normal_rdy_a: assert property (setup && !mv_dst |=> pready)
      else $error("pready not in first access cycle");
   move_timing_a: assert property (mv_setup |=> mv_wait)
      else $error("move answer not three cycles after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   region_err_a: assert property (pready && paddr[15:14] == 2'b11 |-> pslverr)
      else $error("unmapped region without pslverr");
   flat_clean_a: assert property (flat_rd |-> !pslverr && prdata[31:8] == 24'h0)
      else $error("flat read with error or upper bits");
   bank_load_a: assert property (psel && penable && pready && pwrite && paddr == 16'h8000
      |=> bank_select == $past(pwdata[3:0]))
      else $error("bank select not loaded");
   boot_link_a: assert property (boot_ram_program_select
      == secure_regs.external_memory_control[6])
      else $error("boot select differs from control bit");
   boot_hide_a: assert property (flat_rd && boot_ram_program_select
      && paddr[13:11] == 3'b010 |-> prdata == 32'h0)
      else $error("boot bank read not zero");
   sfr_zero_a: assert property (flat_rd && paddr[13:2] > 12'hF95 |-> prdata == 32'h0)
      else $error("unused special location not zero");
   secure_guard_a: assert property (!$stable(secure_regs)
      |-> $past(psel && penable && pready && pwrite))
      else $error("protected value changed without write");
endmodule
bind banked_data_memory bdm_checker bdm_checker_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .secure_regs(secure_regs),
   .boot_ram_program_select(boot_ram_program_select), .bank_select(bank_select));
`default_nettype wire

/* File: tb/cpu_datapath_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_datapath_model (
   // Clock
   input  wire logic        pclk,
   // APB master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [15:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err, output bit ok);
      int n;
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      ok = 1'b0;
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge pclk);
         ok = pready === 1'b1;
      end
      rd = prdata;
      err = pslverr;
      // Released data lines carry no stale value
      {psel, penable, pwdata} <= {1'b0, 1'b0, ~d};
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

/* File: tb/banked_data_memory_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_tb;
   import data_memory_pkg::*;
   logic         pclk;
   logic         presetn;
   logic         psel;
   logic         penable;
   logic         pwrite;
   logic [15:0]  paddr;
   logic [31:0]  pwdata;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   secure_regs_s secure_regs;
   logic         boot_ram_program_select;
   logic [3:0]   bank_select;
   logic         last_err;
   int           fail_count;
   int           num_checks;

   banked_data_memory banked_data_memory_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .secure_regs(secure_regs),
      .boot_ram_program_select(boot_ram_program_select), .bank_select(bank_select));
   cpu_datapath_model cpu_datapath_model_i (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      bit ok;
      cpu_datapath_model_i.xfer(w, a, d, r, last_err, ok);
      if (!ok) begin
         fail_count++;
         tally_and_finish();
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] r;
      acc(1'b1, a, d, r);
   endtask
   task automatic rc(input string what, input logic [15:0] a, input logic [31:0] e);
      logic [31:0] r;
      acc(1'b0, a, 32'h0, r);
      check(what, r, e);
   endtask
   function automatic logic [15:0] fa(input logic [11:0] a);
      return {2'b00, a, 2'b00};
   endfunction
   task automatic unlock;
      wr(fa(12'hF95), 32'h01);
      wr(fa(12'hF95), 32'h03);
   endtask

   task automatic t_flat;
      wr(fa(12'h000), 32'hA5);
      wr(fa(12'hF7F), 32'h3C);
      rc("gpr_low", fa(12'h000), 32'hA5);
      rc("gpr_top", fa(12'hF7F), 32'h3C);
   endtask
   task automatic t_bank;
      wr(16'h8000, 32'hF3);
      check("bank", {28'h0, bank_select}, 32'h3);
      rc("bank_rd", 16'h8000, 32'h3);
      wr(16'h4488, 32'h77);
      rc("banked", fa(12'h322), 32'h77);
      wr(16'h4040, 32'h19);
      rc("acc_low", fa(12'h010), 32'h19);
   endtask
   task automatic t_ptr_move;
      wr(16'h8004, 32'h7A5);
      wr(16'h8010, 32'h5C);
      rc("indirect", fa(12'h7A5), 32'h5C);
      wr(16'h8008, 32'h2C0);
      wr(16'h8014, 32'h4D);
      rc("indirect1", fa(12'h2C0), 32'h4D);
      wr(16'h800C, 32'h2C0);
      rc("indirect2", 16'h8018, 32'h4D);
      wr(fa(12'h123), 32'hAB);
      wr(16'h801C, 32'h123);
      wr(16'h8020, 32'hE45);
      rc("move", fa(12'hE45), 32'hAB);
   endtask
   task automatic t_unimpl;
      wr(fa(12'hF85), 32'hFF);
      rc("sfr_gap", fa(12'hF85), 32'h0);
      rc("sfr_end", fa(12'hFFF), 32'h0);
      rc("bad_reg", 16'hC000, 32'h0);
      check("slverr", {31'h0, last_err}, 32'h1);
   endtask
   task automatic t_lock;
      wr(fa(12'hF91), 32'h55);
      check("locked", {24'h0, secure_regs.watchdog_control}, 32'h0);
      wr(fa(12'hF95), 32'h01);
      rc("armed", 16'h8024, 32'h1);
      wr(fa(12'hF95), 32'h03);
      wr(fa(12'hF91), 32'h55);
      wr(fa(12'hF91), 32'h66);
      rc("one_write", fa(12'hF91), 32'h55);
      rc("acc_sfr", 16'h4244, 32'h55);
      rc("relocked", 16'h8024, 32'h0);
   endtask
   task automatic t_boot;
      wr(fa(12'h400), 32'h11);
      wr(fa(12'h5FF), 32'h33);
      unlock();
      wr(fa(12'hF90), 32'h40);
      check("boot_on", {31'h0, boot_ram_program_select}, 32'h1);
      rc("boot_hide", fa(12'h400), 32'h0);
      wr(fa(12'h5FF), 32'h22);
      unlock();
      wr(fa(12'hF90), 32'h00);
      rc("boot_keep", fa(12'h400), 32'h11);
      rc("boot_drop", fa(12'h5FF), 32'h33);
   endtask
   task automatic t_rereset;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("wd_reset", {24'h0, secure_regs.watchdog_control}, 32'h0);
      check("bank_reset2", {28'h0, bank_select}, 32'h0);
      rc("gpr_kept", fa(12'h123), 32'hAB);
   endtask

   initial begin
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      check("bank_reset", {28'h0, bank_select}, 32'h0);
      t_flat();
      t_bank();
      t_ptr_move();
      t_unimpl();
      t_lock();
      t_boot();
      t_rereset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
